// File: design/scq_params.svh
// constants of the state capture qualifier: offsets, fields, widths
// assumes an apb slave with 12-bit byte address and 32-bit data
//
// Contract
// - prestore keeps two states before each store
// - one prestore qualifier per sequence level
// - prestore forces slow clock period setting
// - history holds two, newest pushes oldest out
// - history written just ahead of stored state
// - eight recognizers, qualifier uses one group
// - one range recognizer, one label, 32 channels
// - range label is first within two pods
// - each label has its own pattern value
// - match stores or triggers per sequencer step
// - trigger at location zero, others signed
// - memory holds up to 1024 states
// - time tags relative or absolute to trigger
// - state tags relative or absolute to trigger
`ifndef SCQ_PARAMS_SVH
`define SCQ_PARAMS_SVH

// ****************************************************************
// register byte offsets; lmask and pat are window numbers in address bits 11:6
// ****************************************************************
`define SCQ_OFS_CTRL 12'h000
`define SCQ_OFS_QUAL0 12'h004
`define SCQ_OFS_QUAL1 12'h008
`define SCQ_OFS_STAT 12'h00c
`define SCQ_OFS_RLO 12'h010
`define SCQ_OFS_RHI 12'h014
`define SCQ_OFS_RIDX 12'h018
`define SCQ_OFS_RDLO 12'h01c
`define SCQ_OFS_RDHI 12'h020
`define SCQ_OFS_RTAG 12'h024
`define SCQ_OFS_LMASK 6'h01
`define SCQ_OFS_PAT 6'h02

// ****************************************************************
// field positions and widths
// ****************************************************************
`define SCQ_CTRL_RUN 0
`define SCQ_CTRL_PRE 1
`define SCQ_CTRL_SLOW 2
`define SCQ_CTRL_CNT 3
`define SCQ_CTRL_ABS 5
`define SCQ_CNT_TIME 2'h1
`define SCQ_CNT_STATE 2'h2
`define SCQ_ST_ARMED 0
`define SCQ_ST_TRIG 1
`define SCQ_ST_DONE 2
`define SCQ_ST_RVAL 3
`define SCQ_ST_RLBL 4
`define SCQ_CH_W 64
`define SCQ_RANGE_W 32
`define SCQ_HIST 2
`define SCQ_NREC 8
`define SCQ_WORD 32

`endif

// File: design/scq_pkg.sv
// types of the state capture qualifier
// assumes scq_params.svh is included by every user
package scq_pkg;
  typedef logic [31:0] scq_word_t; // apb data word
  typedef logic [11:0] scq_addr_t; // apb byte address
  // sequencer steps
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LEVEL0, SEQ_LEVEL1, SEQ_DONE} scq_seq_t;
  // one sequence level qualifier word, high bits first
  typedef struct packed {
    logic [13:0] rsvd;
    logic trig_rng;
    logic [3:0] trig_mask;
    logic trig_grp;
    logic pre_rng;
    logic [3:0] pre_mask;
    logic pre_grp;
    logic st_rng;
    logic [3:0] st_mask;
    logic st_grp;
  } scq_qual_t;
endpackage : scq_pkg

// File: design/scq_top.sv
// state capture qualifier: probe sampling, recognizers, sequencer,
// two-deep prestore history, trace memory and tags, apb registers
// assumes probe clock and data come from the target, asynchronous
`timescale 1ns/1ps
`include "scq_params.svh"

module scq_top #(
  parameter int DEPTH = 1024, // trace memory depth
  parameter int PODS = 4, // probe pods
  parameter int POD_W = 16, // channels per pod
  parameter int LABELS = 4 // channel labels
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire scq_pkg::scq_addr_t PADDR,
  input wire scq_pkg::scq_word_t PWDATA,
  output scq_pkg::scq_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PROBE_CLK,
  input wire logic [PODS*POD_W-1:0] PROBE_DATA,
  output logic TRIG_OUT
);
  import scq_pkg::*;

  // ****************************************************************
  // sizes and checks
  // ****************************************************************
  localparam int CH = PODS * POD_W; // probe channels
  localparam int AW = $clog2(DEPTH); // memory index width
  localparam int ENT_W = CH + `SCQ_WORD; // data plus tag
  // post-trigger fill stops with three slots of headroom
  localparam int POST_LIM = DEPTH / 2 - 3;

  initial begin
    if (CH != `SCQ_CH_W || DEPTH < 16 || (1 << AW) != DEPTH ||
        LABELS < 1 || LABELS > 8 || PODS < 2) begin
      $error("scq_top: unsupported parameters");
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef logic [ENT_W-1:0] ent_t;
  typedef struct packed {
    logic ck1; // probe clock sync stage 1
    logic ck2; // probe clock sync stage 2
    logic ck3; // edge detect
    logic [CH-1:0] d1; // data sync stage 1
    logic [CH-1:0] d2; // data sync stage 2
    scq_seq_t seq; // sequencer step
    logic [AW-1:0] wp; // next write slot
    logic [AW-1:0] trig_wp; // slot of the trigger state
    logic [AW-1:0] post; // states stored after trigger
    logic [1:0] hcnt; // prestore entries held
    logic [`SCQ_HIST-1:0][ENT_W-1:0] hist; // oldest at 0
    logic [DEPTH-1:0][ENT_W-1:0] mem; // trace memory
    logic [31:0] ctrl; // control word
    logic [1:0][31:0] qual; // per level qualifiers
    logic [LABELS-1:0][CH-1:0] lmask; // label channels
    logic [`SCQ_NREC-1:0][CH-1:0] pat; // pattern per recognizer
    logic [31:0] rlo; // range low bound
    logic [31:0] rhi; // range high bound
    logic [AW-1:0] ridx; // signed readback index
    logic [31:0] tstamp; // system clocks
    logic [31:0] sstamp; // sampled states
    logic [31:0] last; // stamp of last stored state
    logic [31:0] trig_stamp; // stamp of trigger state
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic trig_out;
  } st_t;

  st_t r; // registered state
  st_t n; // next state

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // every label must agree with its own pattern bits
  function automatic logic rec_match(input logic [CH-1:0] d, input logic [CH-1:0] p);
    logic ok;
    ok = 1'b1;
    for (int l = 0; l < LABELS; l++) begin
      if (((d ^ p) & r.lmask[l]) != '0) ok = 1'b0;
    end
    return ok;
  endfunction : rec_match

  // gather a label's channels into a packed value, lowest first
  function automatic logic [`SCQ_RANGE_W-1:0] compact(input logic [CH-1:0] d,
                                                      input logic [CH-1:0] m);
    logic [`SCQ_RANGE_W-1:0] v;
    int j;
    v = '0;
    j = 0;
    for (int i = 0; i < CH; i++) begin
      if (m[i] && j < `SCQ_RANGE_W) begin
        v[j] = d[i];
        j++;
      end
    end
    return v;
  endfunction : compact

  // first label spread over one or two pods; msb is valid
  function automatic logic [3:0] pick_label();
    logic [3:0] res;
    int cnt;
    res = '0;
    cnt = 0;
    for (int l = LABELS - 1; l >= 0; l--) begin
      cnt = 0;
      for (int p = 0; p < PODS; p++) begin
        if (|r.lmask[l][p*POD_W +: POD_W]) cnt++;
      end
      if (cnt >= 1 && cnt <= 2) res = {1'b1, 3'(l)};
    end
    return res;
  endfunction : pick_label

  // a qualifier takes its terms from one group only
  function automatic logic qual_hit(input logic grp, input logic [3:0] mask,
                                    input logic rng, input logic [7:0] m,
                                    input logic rh);
    logic [3:0] g;
    g = grp ? m[7:4] : m[3:0];
    return (|(mask & g)) | (rng & rh);
  endfunction : qual_hit

  // tag of one entry from its stamp and its predecessor's
  function automatic logic [31:0] tagval(input logic [31:0] s, input logic [31:0] prev);
    if (r.ctrl[`SCQ_CTRL_CNT +: 2] != `SCQ_CNT_TIME &&
        r.ctrl[`SCQ_CTRL_CNT +: 2] != `SCQ_CNT_STATE) return '0;
    return r.ctrl[`SCQ_CTRL_ABS] ? s : s - prev;
  endfunction : tagval

  // register map membership, shared by read and write
  function automatic logic mapped(input logic [11:0] a);
    logic [2:0] idx;
    idx = a[5:3];
    if (a[1:0] != 2'h0) return 1'b0;
    if (a[11:6] == `SCQ_OFS_LMASK) return int'(idx) < LABELS;
    if (a[11:6] == `SCQ_OFS_PAT) return 1'b1;
    return a <= `SCQ_OFS_RTAG;
  endfunction : mapped

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  logic ev; // one sampled target state
  logic [CH-1:0] smp; // its channel values
  logic [7:0] mt; // recognizer matches
  logic [3:0] lsel; // range label choice
  logic [`SCQ_RANGE_W-1:0] rv; // range operand
  logic rh; // range hit
  scq_qual_t q; // active level qualifier
  logic pre_ok; // prestore permitted
  logic trig_hit, st_hit, pr_hit;
  logic [31:0] stamp; // stamp of the current state
  logic [31:0] prev; // chain of stamps while writing
  logic [AW-1:0] p; // write slot walker
  logic [AW-1:0] nwr; // history slots written this state
  logic [AW-1:0] ph; // physical readback slot
  logic [ENT_W-1:0] rent; // readback entry
  logic access;

  // whole block in one pass; the register stage follows below
  always_comb begin
    n = r;
    // two flops on every probe pin before any logic looks at it
    n.ck1 = PROBE_CLK;
    n.ck2 = r.ck1;
    n.ck3 = r.ck2;
    n.d1 = PROBE_DATA;
    n.d2 = r.d1;
    ev = r.ck2 & ~r.ck3;
    smp = r.d2;
    n.tstamp = r.tstamp + 1'b1;
    if (ev) n.sstamp = r.sstamp + 1'b1;
    stamp = (r.ctrl[`SCQ_CTRL_CNT +: 2] == `SCQ_CNT_STATE) ? r.sstamp : r.tstamp;

    // recognizers and range
    for (int i = 0; i < `SCQ_NREC; i++) begin
      mt[i] = rec_match(smp, r.pat[i]);
    end
    lsel = pick_label();
    rv = compact(smp, r.lmask[lsel[2:0]]);
    // range unavailable when no label fits in two pods
    rh = lsel[3] & (rv >= r.rlo) & (rv <= r.rhi);

    // the active level picks its own qualifiers
    q = scq_qual_t'((r.seq == SEQ_LEVEL1) ? r.qual[1] : r.qual[0]);
    pre_ok = r.ctrl[`SCQ_CTRL_PRE] & r.ctrl[`SCQ_CTRL_SLOW];
    trig_hit = (r.seq == SEQ_LEVEL0) &
               qual_hit(q.trig_grp, q.trig_mask, q.trig_rng, mt, rh);
    st_hit = qual_hit(q.st_grp, q.st_mask, q.st_rng, mt, rh);
    pr_hit = pre_ok & qual_hit(q.pre_grp, q.pre_mask, q.pre_rng, mt, rh);

    p = r.wp;
    prev = r.last;
    nwr = '0;
    if (ev && (r.seq == SEQ_LEVEL0 || r.seq == SEQ_LEVEL1)) begin
      if (trig_hit || st_hit) begin
        // held history goes in first, oldest first
        for (int k = 0; k < `SCQ_HIST; k++) begin
          if (k < int'(r.hcnt)) begin
            n.mem[p] = {r.hist[k][ENT_W-1 -: CH], tagval(r.hist[k][31:0], prev)};
            prev = r.hist[k][31:0];
            p = p + 1'b1;
            nwr = nwr + 1'b1;
          end
        end
        n.mem[p] = {smp, tagval(stamp, prev)};
        n.last = stamp;
        n.hcnt = '0;
        if (trig_hit) begin
          // trigger slot becomes location zero
          n.trig_wp = p;
          n.trig_stamp = stamp;
          n.seq = SEQ_LEVEL1;
          n.trig_out = 1'b1;
        end else if (r.seq == SEQ_LEVEL1) begin
          n.post = r.post + nwr + 1'b1;
          // stop short of the oldest pre-trigger states
          if (int'(n.post) >= POST_LIM) n.seq = SEQ_DONE;
        end
        n.wp = p + 1'b1;
      end else if (pr_hit) begin
        // newest pushes the oldest out once two are held
        if (r.hcnt == 2'(`SCQ_HIST)) begin
          n.hist[0] = r.hist[1];
          n.hist[1] = {smp, stamp};
        end else begin
          n.hist[r.hcnt[0]] = {smp, stamp};
          n.hcnt = r.hcnt + 1'b1;
        end
      end
    end

    // readback slot relative to trigger, wraps with memory
    ph = r.trig_wp + r.ridx;
    rent = r.mem[ph];

    // apb: one wait state, answer registered
    access = PSEL & PENABLE;
    n.pready = access & ~r.pready;
    n.pslverr = 1'b0;
    if (access && !r.pready) begin
      n.pslverr = ~mapped(PADDR);
      n.prdata = '0;
      if (!PWRITE && mapped(PADDR)) begin
        if (PADDR[11:6] == `SCQ_OFS_LMASK) begin
          n.prdata = r.lmask[PADDR[5:3]][PADDR[2]*`SCQ_WORD +: `SCQ_WORD];
        end else if (PADDR[11:6] == `SCQ_OFS_PAT) begin
          n.prdata = r.pat[PADDR[5:3]][PADDR[2]*`SCQ_WORD +: `SCQ_WORD];
        end else begin
          unique case (PADDR)
            `SCQ_OFS_CTRL: n.prdata = r.ctrl;
            `SCQ_OFS_QUAL0: n.prdata = r.qual[0];
            `SCQ_OFS_QUAL1: n.prdata = r.qual[1];
            `SCQ_OFS_STAT: begin
              n.prdata[`SCQ_ST_ARMED] = (r.seq == SEQ_LEVEL0) | (r.seq == SEQ_LEVEL1);
              n.prdata[`SCQ_ST_TRIG] = (r.seq == SEQ_LEVEL1) | (r.seq == SEQ_DONE);
              n.prdata[`SCQ_ST_DONE] = (r.seq == SEQ_DONE);
              n.prdata[`SCQ_ST_RVAL] = lsel[3];
              n.prdata[`SCQ_ST_RLBL +: 3] = lsel[2:0];
            end
            `SCQ_OFS_RLO: n.prdata = r.rlo;
            `SCQ_OFS_RHI: n.prdata = r.rhi;
            `SCQ_OFS_RIDX: n.prdata = 32'(signed'(r.ridx));
            `SCQ_OFS_RDLO: n.prdata = rent[`SCQ_WORD +: `SCQ_WORD];
            `SCQ_OFS_RDHI: n.prdata = rent[ENT_W-1 -: `SCQ_WORD];
            // absolute tags are told against the trigger stamp
            `SCQ_OFS_RTAG: n.prdata = r.ctrl[`SCQ_CTRL_ABS] ?
                                      rent[31:0] - r.trig_stamp : rent[31:0];
            default: n.prdata = '0;
          endcase
        end
      end
    end

    // writes land at the edge that completes the transfer
    if (access && r.pready && PWRITE && mapped(PADDR)) begin
      if (PADDR[11:6] == `SCQ_OFS_LMASK) begin
        n.lmask[PADDR[5:3]][PADDR[2]*`SCQ_WORD +: `SCQ_WORD] = PWDATA;
      end else if (PADDR[11:6] == `SCQ_OFS_PAT) begin
        n.pat[PADDR[5:3]][PADDR[2]*`SCQ_WORD +: `SCQ_WORD] = PWDATA;
      end else begin
        unique case (PADDR)
          `SCQ_OFS_CTRL: begin
            n.ctrl = PWDATA;
            // prestore cannot live with the fast period setting
            if (PWDATA[`SCQ_CTRL_PRE]) n.ctrl[`SCQ_CTRL_SLOW] = 1'b1;
            if (PWDATA[`SCQ_CTRL_RUN] && !r.ctrl[`SCQ_CTRL_RUN]) begin
              n.seq = SEQ_LEVEL0;
              n.wp = '0;
              n.trig_wp = '0;
              n.post = '0;
              n.hcnt = '0;
              n.last = '0;
              n.tstamp = '0;
              n.sstamp = '0;
              n.trig_out = 1'b0;
            end else if (!PWDATA[`SCQ_CTRL_RUN]) begin
              n.seq = SEQ_IDLE;
            end
          end
          `SCQ_OFS_QUAL0: n.qual[0] = PWDATA;
          `SCQ_OFS_QUAL1: n.qual[1] = PWDATA;
          `SCQ_OFS_RLO: n.rlo = PWDATA;
          `SCQ_OFS_RHI: n.rhi = PWDATA;
          `SCQ_OFS_RIDX: n.ridx = PWDATA[AW-1:0];
          default: n.ridx = r.ridx; // read-only words ignore writes
        endcase
      end
    end
  end

  // ****************************************************************
  // register stage
  // ****************************************************************
  // one flop bank for the whole block, cleared by reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs, each straight from a flop
  // ****************************************************************
  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign TRIG_OUT = r.trig_out;

endmodule : scq_top

// File: test/scq_chk.sv
// checker: bus handshake, error answers and trigger timing of scq_top
// assumes one clock domain, bound to the ports of scq_top
`timescale 1ns/1ps
`include "scq_params.svh"
module scq_chk #(
  parameter int PODS = 4, // probe pods
  parameter int POD_W = 16 // channels per pod
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire scq_pkg::scq_addr_t PADDR,
  input wire scq_pkg::scq_word_t PWDATA,
  input wire scq_pkg::scq_word_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PROBE_CLK,
  input wire logic [PODS*POD_W-1:0] PROBE_DATA,
  input wire logic TRIG_OUT
);
  import scq_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic bad; // misaligned or outside every register window
  logic run_wr; // completed write of ctrl with the run bit set
  assign bad = PADDR[1:0] != 2'h0 || !(PADDR <= `SCQ_OFS_RTAG ||
    (PADDR >= 12'h040 && PADDR < 12'h060) || (PADDR >= 12'h080 && PADDR < 12'h0c0));
  assign run_wr = PREADY && PSEL && PWRITE && PADDR == `SCQ_OFS_CTRL && PWDATA[0];
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_ready_wait: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("ready not one wait state after access");
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  chk_ready_cause: assert property (PREADY |-> s_access and $past(PSEL && PENABLE))
    else $error("ready without access");
  chk_err_map: assert property (PREADY && bad |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  chk_ok_map: assert property (PREADY && !bad |-> !PSLVERR) else $error("mapped access refused");
  chk_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  chk_trig_late: assert property ($rose(TRIG_OUT) |-> $past(PROBE_CLK, 3))
    else $error("trigger not caused by a target state");
  chk_trig_clear: assert property ($fell(TRIG_OUT) |-> $past(run_wr) || $past(run_wr, 2))
    else $error("trigger dropped without run start");
endmodule : scq_chk
bind scq_top scq_chk #(.PODS(PODS), .POD_W(POD_W)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PROBE_CLK(PROBE_CLK),
  .PROBE_DATA(PROBE_DATA), .TRIG_OUT(TRIG_OUT));

// File: test/scq_tgt.sv
// model of the target bus seen through the probe pods
// assumes the caller enters put right after a system clock edge
`timescale 1ns/1ps
`include "scq_params.svh"
module scq_tgt (
  input wire logic clk,
  output logic probe_clk,
  output logic [`SCQ_CH_W-1:0] probe_data
);
  // target clock stands still low between states
  initial begin
    probe_clk = 1'b0;
    probe_data = 64'h0;
  end
  // one state: setup, clock high 4 cycles, low 4; data flips once hold is over
  task automatic put(input logic [`SCQ_CH_W-1:0] d);
    probe_data <= d;
    repeat (2) @(posedge clk);
    probe_clk <= 1'b1;
    repeat (4) @(posedge clk);
    probe_clk <= 1'b0;
    repeat (2) @(posedge clk);
    probe_data <= ~d; // stale data must never be taken for a state
    repeat (2) @(posedge clk);
  endtask : put
endmodule : scq_tgt

// File: test/tb.sv
// self-checking bench of scq_top: registers, range label, capture
// assumes the target model drives the probe pins
`timescale 1ns/1ps
`include "scq_params.svh"
module tb;
  import scq_pkg::*;
  logic CLK_SYS = 1'b0, RSTN = 1'b0, PSEL, PENABLE, PWRITE;
  scq_addr_t PADDR;
  scq_word_t PWDATA, PRDATA, rd;
  logic PREADY, PSLVERR, PROBE_CLK, TRIG_OUT, er;
  logic [63:0] PROBE_DATA;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  // short memory keeps the run brief
  scq_top #(.DEPTH(16)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PROBE_CLK(PROBE_CLK), .PROBE_DATA(PROBE_DATA),
    .TRIG_OUT(TRIG_OUT));
  scq_tgt tgt (.clk(CLK_SYS), .probe_clk(PROBE_CLK), .probe_data(PROBE_DATA));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string n, input scq_word_t e, input scq_word_t s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one bus transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input scq_addr_t a, input scq_word_t d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic rchk(input scq_addr_t a, input scq_word_t e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rchk
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    rchk(`SCQ_OFS_CTRL, 32'h0, "ctrl reset");
    apb(1'b1, `SCQ_OFS_CTRL, 32'h2);
    rchk(`SCQ_OFS_CTRL, 32'h6, "ctrl slow forced");
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, `SCQ_OFS_CTRL, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_range;
    apb(1'b1, 12'h040, 32'h00010001); // label 0 spans three pods
    apb(1'b1, 12'h044, 32'h1);
    apb(1'b1, 12'h04c, 32'h100); // label 1 holds channel 40 only
    rchk(`SCQ_OFS_STAT, 32'h18, "range on label 1");
    apb(1'b1, 12'h04c, 32'h0);
    rchk(`SCQ_OFS_STAT, 32'h0, "range unavailable");
    apb(1'b1, 12'h040, 32'hff);
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h04c, 32'h100);
    rchk(`SCQ_OFS_STAT, 32'h8, "range on label 0");
    $display("test range done");
  endtask : t_range
  task automatic t_cap;
    scq_word_t ed [4] = '{32'h2cc, 32'h3cc, 32'h434, 32'h555};
    scq_word_t et [4] = '{32'h0, 32'h1, 32'h2, 32'h2};
    // absolute tags are told against the trigger's state count of 4
    scq_word_t ea [4] = '{32'hfffffffd, 32'hfffffffe, 32'h0, 32'h2};
    // state 3 differs on label 1 only
    logic [63:0] st [7] = '{64'h1cc, 64'h2cc, 64'h3cc, 64'h10000000434, 64'h434, 64'h777,
                            64'h555};
    apb(1'b1, 12'h080, 32'h34); // recognizer a: trigger
    apb(1'b1, 12'h088, 32'h55); // recognizer b: store
    apb(1'b1, 12'h090, 32'hcc); // recognizer c: prestore
    apb(1'b1, `SCQ_OFS_QUAL0, 32'h2200);
    apb(1'b1, `SCQ_OFS_QUAL1, 32'h4);
    // second run: absolute tags, trigger from group e-h; recognizer a would
    // fire on the first state if the group choice were ignored
    for (int run = 0; run < 2; run++) begin
      if (run == 1) begin
        apb(1'b1, `SCQ_OFS_CTRL, 32'h0);
        apb(1'b1, 12'h080, 32'hcc);
        apb(1'b1, 12'h0a0, 32'h34); // recognizer e: trigger
        apb(1'b1, `SCQ_OFS_QUAL0, 32'h3200);
      end
      // run, prestore, slow, state count; absolute in the second run
      apb(1'b1, `SCQ_OFS_CTRL, run ? 32'h37 : 32'h17);
      @(posedge CLK_SYS);
      chk("trigger cleared at run start", 32'h0, {31'h0, TRIG_OUT});
      for (int s = 0; s < 7; s++) begin
        if (s == 4) chk("no trigger on partial match", 32'h0, {31'h0, TRIG_OUT});
        if (s == 5) chk("trigger seen", 32'h1, {31'h0, TRIG_OUT});
        tgt.put(st[s]);
      end
      rchk(`SCQ_OFS_STAT, 32'hb, "armed and triggered");
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, `SCQ_OFS_RIDX, scq_word_t'(i - 2));
        rchk(`SCQ_OFS_RDLO, ed[i], "stored state");
        rchk(`SCQ_OFS_RDHI, 32'h0, "stored state high");
        if (run == 1) rchk(`SCQ_OFS_RTAG, ea[i], "absolute tag");
        else if (i > 0) rchk(`SCQ_OFS_RTAG, et[i], "state tag");
      end
    end
    $display("test capture done");
  endtask : t_cap
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // main sequence after 20 cycles of reset
  initial begin
    // bus idle while reset is held
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWRITE <= 1'b0;
    PADDR <= 12'h000;
    PWDATA <= 32'h0;
    repeat (20) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    t_regs;
    t_range;
    t_cap;
    summarize;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end
endmodule : tb
